// file: include/lbc_pkg.sv
// lbc_pkg: constants and carrier types for the led brightness control core.
// assumes: imported whole by every design file of the block.
package lbc_pkg;

  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [7:0] LBC_ADDR_ACTIVE = 8'h00;
  localparam logic [7:0] LBC_ADDR_STATUS = 8'h04;
  localparam logic [7:0] LBC_ADDR_CTRL = 8'h08;
  localparam int LBC_ADDR_W = 8;

  // ==========================================================
  // field positions
  localparam int LBC_ACT_PRIMARY_LSB = 0;
  localparam int LBC_ACT_FHI_LSB = 8;
  localparam int LBC_ACT_FLO_LSB = 12;
  localparam int LBC_ACT_AUX_LSB = 16;
  localparam int LBC_ACT_GPO_BIT = 18;
  localparam int LBC_ACT_SELSW_BIT = 19;
  localparam int LBC_ST_PUMP_LSB = 0;
  localparam int LBC_ST_SELHI_BIT = 2;
  localparam int LBC_ST_PEN_BIT = 3;
  localparam int LBC_ST_FEN_BIT = 4;
  localparam int LBC_ST_SUPPLY_BIT = 5;
  localparam int LBC_CTRL_HOLD1X_BIT = 0;
  // serial control byte
  localparam int LBC_SER_SELSW_BIT = 7;
  localparam int LBC_SER_GPO_BIT = 6;
  localparam int LBC_SER_AUX_LSB = 0;

  // ==========================================================
  // reset values and counts
  localparam logic LBC_CTRL_HOLD1X_RESET = 1'b0;
  localparam logic [31:0] LBC_RDATA_RESET = 32'h0000_0000;
  localparam logic [3:0] LBC_BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] LBC_NUM_DATA_REGS = 2'h3;
  localparam logic [1:0] LBC_IDX_PRIMARY = 2'h0;
  localparam logic [1:0] LBC_IDX_FLASH = 2'h1;
  localparam logic [1:0] LBC_IDX_CONTROL = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    LBC_PUMP_1X,
    LBC_PUMP_1P5X,
    LBC_PUMP_2X
  } lbc_pump_t;

  typedef struct packed {
    logic sel_sw;
    logic gpo_mode;
    logic [1:0] aux_level;
    logic [3:0] flash_lo;
    logic [3:0] flash_hi;
    logic [7:0] primary;
  } lbc_held_t;

  typedef struct packed {
    logic frame_start;
    logic bit_valid;
    logic bit_data;
    logic frame_stop;
  } lbc_link_in_t;

endpackage : lbc_pkg

// file: core/lbc_link_shift.sv
// lbc_link_shift: serial-clock side of the core; shifts bits into the held
// data registers and hands a snapshot to the bus clock on each stop.
// assumes: the serial port state machine strobes one bit per link clock.
`timescale 1ns/100ps
`default_nettype none
module lbc_link_shift
  import lbc_pkg::*;
(
  input wire logic link_clk, // serial clock
  input wire logic presetn, // async reset, active low
  input wire logic supply_ok, // logic supply above lockout, async pin
  input wire lbc_link_in_t link_in, // strobes from the serial state machine
  output lbc_held_t snapshot, // held data frozen at last stop
  output logic load_toggle // flips once per stop
);

  typedef struct packed {
    // holds supply low, not supply ok, so reset leaves the link unlocked; the link
    // clock may start with the frame itself, and a synchroniser still filling would
    // swallow the first data bit
    logic [1:0] low_sync;
    logic [7:0] shift;
    logic [3:0] count;
    logic [1:0] index;
    lbc_held_t held;
    lbc_held_t snap;
    logic toggle;
  } lbc_link_st_t;

  lbc_link_st_t s;
  lbc_link_st_t next_s;
  logic [7:0] next_byte;

  always_comb begin
    next_s = s;
    next_s.low_sync = {s.low_sync[0], !supply_ok};
    next_byte = {s.shift[6:0], link_in.bit_data}; // msb first
    if (link_in.frame_start) begin
      next_s.count = 4'h0;
      next_s.index = LBC_IDX_PRIMARY;
    end else if (link_in.bit_valid && s.index < LBC_NUM_DATA_REGS) begin
      next_s.shift = next_byte; // one bit per clock
      next_s.count = s.count + 4'h1;
      if (s.count + 4'h1 == LBC_BITS_PER_BYTE) begin
        next_s.count = 4'h0;
        next_s.index = s.index + 2'h1;
        case (s.index)
          LBC_IDX_PRIMARY: next_s.held.primary = next_byte;
          LBC_IDX_FLASH: next_s.held.flash_hi = next_byte[7:4];
          default: begin
            next_s.held.flash_lo = next_byte[3:0];
          end
        endcase
        if (s.index == LBC_IDX_CONTROL) begin
          next_s.held.flash_lo = s.held.flash_lo;
          next_s.held.sel_sw = next_byte[LBC_SER_SELSW_BIT];
          next_s.held.gpo_mode = next_byte[LBC_SER_GPO_BIT];
          next_s.held.aux_level = next_byte[LBC_SER_AUX_LSB +: 2];
        end else if (s.index == LBC_IDX_FLASH) begin
          next_s.held.flash_lo = next_byte[3:0];
        end
      end
    end
    if (link_in.frame_stop) begin
      next_s.snap = s.held; // frozen until the next stop
      next_s.toggle = ~s.toggle;
    end
    if (s.low_sync[1]) begin
      next_s.shift = 8'h00;
      next_s.count = 4'h0;
      next_s.held = '0;
    end
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign snapshot = s.snap;
  assign load_toggle = s.toggle;

endmodule : lbc_link_shift
`default_nettype wire

// file: core/lbc_core.sv
// lbc_core: brightness register bank with charge pump mode control and apb
// status access; the serial link side lives in lbc_link_shift.
// assumes: pins are asynchronous to pclk; link_clk is the serial clock.
`timescale 1ns/100ps
`default_nettype none
module lbc_core
  import lbc_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic link_clk, // serial clock
  input wire lbc_link_in_t link_in, // serial state machine strobes
  input wire logic supply_ok, // logic supply above lockout
  input wire logic flash_level_select, // flash level select pin
  input wire logic primary_dropout, // dropout seen on a primary sink
  input wire logic flash_dropout, // dropout seen on flash_led_sinks
  output logic [7:0] primary_level, // active primary code
  output logic primary_en, // primary group enabled
  output logic [3:0] flash_level, // applied flash code
  output logic flash_en, // flash_led_sinks enabled
  output logic [1:0] aux_level, // indicator code
  output logic aux_gpo_mode, // indicator used as plain output
  output logic aux_gpo_state, // indicator output state in gpo mode
  output lbc_pump_t pump_mode // multiplier on pump_output_rail
);

  // ==========================================================
  // state
  typedef struct packed {
    lbc_held_t active;
    logic [2:0] load_sync;
    logic [1:0] sel_sync;
    logic sel_prev;
    logic [1:0] pdrop_sync;
    logic [1:0] fdrop_sync;
    logic drop_prev;
    logic [1:0] ok_sync;
    lbc_pump_t pump;
    logic hold_1x;
    logic [31:0] rdata;
    logic [7:0] primary_level;
    logic primary_en;
    logic [3:0] flash_level;
    logic flash_en;
    logic aux_gpo_state;
  } lbc_core_st_t;

  lbc_core_st_t s;
  lbc_core_st_t next_s;
  lbc_held_t snapshot;
  logic load_toggle;

  // ==========================================================
  // link side
  lbc_link_shift u_link (
    .link_clk(link_clk),
    .presetn(presetn),
    .supply_ok(supply_ok),
    .link_in(link_in),
    .snapshot(snapshot),
    .load_toggle(load_toggle)
  );

  // ==========================================================
  // decoded helpers
  logic load_pulse;
  logic sel_high;
  logic sel_fall;
  logic drop_now;
  logic drop_rise;
  logic lockout;
  logic setup;
  logic access;
  logic [LBC_ADDR_W-1:0] addr;
  logic mapped;
  lbc_held_t next_active;
  logic [3:0] chosen;

  always_comb begin
    addr = paddr[LBC_ADDR_W-1:0];
    mapped = (paddr[31:LBC_ADDR_W] == 24'h00_0000) &&
             (addr == LBC_ADDR_ACTIVE || addr == LBC_ADDR_STATUS || addr == LBC_ADDR_CTRL);
    setup = psel && !penable;
    access = psel && penable;
    lockout = !s.ok_sync[1];
    // toggle seen past the second stage; snapshot has long settled by then
    load_pulse = s.load_sync[2] ^ s.load_sync[1];
    sel_fall = s.sel_prev && !s.sel_sync[1];
    // only enabled primary or flash sinks count; the indicator has no input
    drop_now = (s.pdrop_sync[1] && s.primary_en) ||
               (s.fdrop_sync[1] && s.flash_en);
    drop_rise = drop_now && !s.drop_prev;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.load_sync = {s.load_sync[1:0], load_toggle};
    next_s.sel_sync = {s.sel_sync[0], flash_level_select};
    next_s.sel_prev = s.sel_sync[1];
    next_s.pdrop_sync = {s.pdrop_sync[0], primary_dropout};
    next_s.fdrop_sync = {s.fdrop_sync[0], flash_dropout};
    next_s.drop_prev = drop_now;
    next_s.ok_sync = {s.ok_sync[0], supply_ok};

    // active registers
    next_active = s.active;
    if (load_pulse) begin
      next_active = snapshot; // all fields at once
    end
    next_s.active = next_active;

    // pump multiplier
    if (load_pulse || sel_fall) begin
      next_s.pump = LBC_PUMP_1X;
    end else if (drop_rise && !s.hold_1x) begin
      case (s.pump)
        LBC_PUMP_1X: next_s.pump = LBC_PUMP_1P5X;
        LBC_PUMP_1P5X: next_s.pump = LBC_PUMP_2X;
        LBC_PUMP_2X: next_s.pump = LBC_PUMP_2X;
        default: next_s.pump = LBC_PUMP_1X;
      endcase
    end
    if (s.hold_1x) begin
      next_s.pump = LBC_PUMP_1X;
    end

    // outputs derived from the new active set
    next_s.primary_level = next_active.primary;
    next_s.primary_en = (next_active.primary != 8'h00);
    if (next_active.sel_sw || s.sel_sync[1]) begin
      chosen = next_active.flash_hi;
    end else begin
      chosen = next_active.flash_lo;
    end
    next_s.flash_level = chosen;
    next_s.flash_en = (chosen != 4'h0);
    next_s.aux_gpo_state = next_active.aux_level[0];

    // apb: read data sampled in the setup cycle so prdata comes from a flop
    if (setup && !pwrite) begin
      next_s.rdata = LBC_RDATA_RESET;
      case (addr)
        LBC_ADDR_ACTIVE: begin
          next_s.rdata[LBC_ACT_PRIMARY_LSB +: 8] = s.active.primary;
          next_s.rdata[LBC_ACT_FHI_LSB +: 4] = s.active.flash_hi;
          next_s.rdata[LBC_ACT_FLO_LSB +: 4] = s.active.flash_lo;
          next_s.rdata[LBC_ACT_AUX_LSB +: 2] = s.active.aux_level;
          next_s.rdata[LBC_ACT_GPO_BIT] = s.active.gpo_mode;
          next_s.rdata[LBC_ACT_SELSW_BIT] = s.active.sel_sw;
        end
        LBC_ADDR_STATUS: begin
          next_s.rdata[LBC_ST_PUMP_LSB +: 2] = s.pump;
          next_s.rdata[LBC_ST_SELHI_BIT] = s.active.sel_sw || s.sel_sync[1];
          next_s.rdata[LBC_ST_PEN_BIT] = s.primary_en;
          next_s.rdata[LBC_ST_FEN_BIT] = s.flash_en;
          next_s.rdata[LBC_ST_SUPPLY_BIT] = s.ok_sync[1];
        end
        LBC_ADDR_CTRL: begin
          next_s.rdata[LBC_CTRL_HOLD1X_BIT] = s.hold_1x;
        end
        default: begin
          next_s.rdata = LBC_RDATA_RESET;
        end
      endcase
    end
    if (access && pwrite && addr == LBC_ADDR_CTRL && mapped) begin
      next_s.hold_1x = pwdata[LBC_CTRL_HOLD1X_BIT];
    end

    // lockout clears everything except the synchronisers, edge history and read data
    if (lockout) begin
      next_s.active = '0;
      next_s.pump = LBC_PUMP_1X;
      next_s.hold_1x = LBC_CTRL_HOLD1X_RESET;
      next_s.primary_level = 8'h00;
      next_s.primary_en = 1'b0;
      next_s.flash_level = 4'h0;
      next_s.flash_en = 1'b0;
      next_s.aux_gpo_state = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = s.rdata;
  assign pready = access;
  assign pslverr = access && !mapped;
  assign primary_level = s.primary_level;
  assign primary_en = s.primary_en;
  assign flash_level = s.flash_level;
  assign flash_en = s.flash_en;
  assign aux_level = s.active.aux_level;
  assign aux_gpo_mode = s.active.gpo_mode;
  assign aux_gpo_state = s.aux_gpo_state;
  assign pump_mode = s.pump;

endmodule : lbc_core
`default_nettype wire

// file: verif/lbc_core_checker.sv
// lbc_core_checker: concurrent checks on the ports of lbc_core.
// assumes: bound to lbc_core; every check runs in the pclk domain.
`timescale 1ns/100ps
`default_nettype none
module lbc_core_checker
  import lbc_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic supply_ok, // logic supply above lockout
  input wire logic flash_level_select, // select pin
  input wire logic primary_dropout, // primary dropout
  input wire logic flash_dropout, // flash dropout
  input wire logic [7:0] primary_level, // primary code
  input wire logic primary_en, // primary enable
  input wire logic [3:0] flash_level, // flash code
  input wire logic flash_en, // flash enable
  input wire logic [1:0] aux_level, // indicator code
  input wire logic aux_gpo_mode, // indicator as output
  input wire logic aux_gpo_state, // indicator output state
  input wire lbc_pump_t pump_mode // pump multiplier
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // assertions
  pen_zero_a: assert property (primary_en == (primary_level != 8'h00))
    else $error("primary enable disagrees with level");
  fen_zero_a: assert property (flash_en == (flash_level != 4'h0))
    else $error("flash enable disagrees with level");
  pump_step_a: assert property ($past(pump_mode) == LBC_PUMP_1X |-> pump_mode != LBC_PUMP_2X)
    else $error("pump skipped the middle mode");
  pump_hold_a: assert property ((!primary_dropout && !flash_dropout) [*5] |=> pump_mode <= $past(pump_mode))
    else $error("pump stepped up without dropout");
  sel_fall_a: assert property ($fell(flash_level_select) |-> ##[1:6] pump_mode == LBC_PUMP_1X)
    else $error("pump not back to 1x after select fall");
  lockout_zero_a: assert property (!supply_ok [*4] |-> primary_level == 8'h00 && flash_level == 4'h0
    && aux_level == 2'h0 && pump_mode == LBC_PUMP_1X)
    else $error("outputs not cleared in lockout");
  gpo_state_a: assert property (aux_gpo_mode |-> aux_gpo_state == aux_level[0])
    else $error("indicator output state wrong");
  ready_now_a: assert property (pready == (psel && penable))
    else $error("pready not in access phase");
  err_data_a: assert property (pslverr |-> psel && penable && (pwrite || prdata == 32'h0000_0000))
    else $error("bad error response");
  // ==========================================================
  // covers
  pump_top_c: cover property (pump_mode == LBC_PUMP_2X);
  err_seen_c: cover property (pslverr);
  sel_fall_c: cover property ($fell(flash_level_select) && pump_mode != LBC_PUMP_1X);
endmodule : lbc_core_checker
bind lbc_core lbc_core_checker lbc_core_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .supply_ok(supply_ok), .flash_level_select(flash_level_select), .primary_dropout(primary_dropout),
  .flash_dropout(flash_dropout), .primary_level(primary_level), .primary_en(primary_en),
  .flash_level(flash_level), .flash_en(flash_en), .aux_level(aux_level), .aux_gpo_mode(aux_gpo_mode),
  .aux_gpo_state(aux_gpo_state), .pump_mode(pump_mode));
`default_nettype wire

// file: verif/lbc_host_model.sv
// lbc_host_model: serial host; makes the link clock only inside frames.
// assumes: the bench calls send_frame; lines change while link_clk is low.
`timescale 1ns/100ps
`default_nettype none
module lbc_host_model
  import lbc_pkg::*;
(
  output var logic link_clk, // serial clock, 160 ns in frames
  output var lbc_link_in_t link_in // strobes toward the core
);
  initial begin
    link_clk = 1'b0;
    link_in = '0;
  end
  // ==========================================================
  // one strobe per link clock edge
  task automatic edge_out(input logic fs, input logic bv, input logic bd, input logic st);
    link_in = '{fs, bv, bd, st};
    #80 link_clk = 1'b1;
    #80 link_clk = 1'b0;
  endtask : edge_out
  task automatic send_frame(input logic [23:0] data);
    edge_out(1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 24; i++) begin
      edge_out(1'b0, 1'b1, data[23 - i], 1'b0);
    end
    edge_out(1'b0, 1'b0, 1'b0, 1'b1);
    // released data line shows no stale bit between frames
    link_in = '{1'b0, 1'b0, ~link_in.bit_data, 1'b0};
  endtask : send_frame
endmodule : lbc_host_model
`default_nettype wire

// file: verif/tb_top.sv
// tb_top: self-checking bench for lbc_core with an apb master and a host model.
// assumes: lbc_pkg compiled first; checker bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module tb_top import lbc_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, supply_ok, flash_level_select, primary_dropout, flash_dropout;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, er, link_clk, primary_en, flash_en, aux_gpo_mode, aux_gpo_state;
  logic [7:0] primary_level;
  logic [3:0] flash_level;
  logic [1:0] aux_level;
  lbc_pump_t pump_mode;
  lbc_link_in_t link_in;
  int error_cnt, comparisons, cycles;
  lbc_core lbc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
    .link_in(link_in), .supply_ok(supply_ok), .flash_level_select(flash_level_select),
    .primary_dropout(primary_dropout), .flash_dropout(flash_dropout), .primary_level(primary_level),
    .primary_en(primary_en), .flash_level(flash_level), .flash_en(flash_en), .aux_level(aux_level),
    .aux_gpo_mode(aux_gpo_mode), .aux_gpo_state(aux_gpo_state), .pump_mode(pump_mode));
  lbc_host_model lbc_host_model_inst (.link_clk(link_clk), .link_in(link_in));
  always #5 pclk = ~pclk;
  // ==========================================================
  // shared tasks
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_clk
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic load(input logic [23:0] d);
    lbc_host_model_inst.send_frame(d);
    wait_clk(10);
  endtask : load
  task automatic drop(input logic fl);
    if (fl) flash_dropout <= 1'b1;
    else primary_dropout <= 1'b1;
    wait_clk(4);
    primary_dropout <= 1'b0;
    flash_dropout <= 1'b0;
    wait_clk(6);
  endtask : drop
  // ==========================================================
  // scenarios
  task automatic s_bus();
    apb(1'b0, 32'h0000_0008, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 32'h0000_0000, 32'hffff_ffff);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, 32'h0000_000c, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
  endtask : s_bus
  task automatic s_load();
    load(24'ha5_93_42);
    chk({primary_level, flash_level, aux_level, aux_gpo_mode, aux_gpo_state}, 32'h0000_a53a);
    apb(1'b0, 32'h0000_0000, 32'h0);
    chk(rd, 32'h0006_39a5);
    flash_level_select <= 1'b1;
    wait_clk(6);
    chk({28'h0, flash_level}, 32'h9);
    apb(1'b0, 32'h0000_0004, 32'h0);
    chk(rd, 32'h0000_003c);
    flash_level_select <= 1'b0;
    wait_clk(6);
  endtask : s_load
  task automatic s_select();
    load(24'h00_50_80);
    chk({primary_en, flash_level}, 32'h05);
    load(24'h01_0a_00);
    chk({primary_level, flash_level}, 32'h01a);
    flash_level_select <= 1'b1;
    wait_clk(6);
    chk({flash_en, flash_level}, 32'h0);
  endtask : s_select
  task automatic s_pump();
    load(24'hff_f0_00);
    drop(1'b1);
    chk(pump_mode, LBC_PUMP_1P5X);
    drop(1'b0);
    drop(1'b0);
    chk(pump_mode, LBC_PUMP_2X);
    flash_level_select <= 1'b0;
    wait_clk(6);
    chk(pump_mode, LBC_PUMP_1X);
    drop(1'b1);
    chk(pump_mode, LBC_PUMP_1X);
    drop(1'b0);
    load(24'hff_f0_00);
    chk(pump_mode, LBC_PUMP_1X);
    apb(1'b1, 32'h0000_0008, 32'h1);
    drop(1'b0);
    chk(pump_mode, LBC_PUMP_1X);
  endtask : s_pump
  task automatic s_lockout();
    supply_ok <= 1'b0;
    wait_clk(6);
    chk({primary_level, flash_level, aux_level, pump_mode}, 32'h0);
    apb(1'b0, 32'h0000_0008, 32'h0);
    chk(rd, 32'h0);
    supply_ok <= 1'b1;
    wait_clk(4);
  endtask : s_lockout
  initial begin
    {pclk, presetn, psel, penable, pwrite, flash_level_select, primary_dropout, flash_dropout} = '0;
    {paddr, pwdata, error_cnt, comparisons, cycles} = '0;
    supply_ok = 1'b1;
    wait_clk(8);
    presetn <= 1'b1;
    s_bus();
    s_load();
    s_select();
    s_pump();
    s_lockout();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
